// file: rtl/lcs_pkg.sv
// constants for the link condition status register bank
// assumes a 32-bit axi4-lite master and a symbol pair classifier on clk_sys
// Function
// - five-bit fixed revision code sits in bits 15..11 of the first status word
// - carrier loss bit reads the inverse of the received-energy input
// - prior condition loads only when leaving quiet, master, halt or long idle
// - prior condition codes: 00 quiet, 01 master, 10 halt, 11 long idle
// - current condition codes 000 noise through 111 long idle as listed
// - the tracker's single state bit is readable in the first status word
// - unknown flag set while recognising, cleared once a condition is known
// - sixteen like symbols enter a condition, four for idle
// - three-bit like pair counter; at seven update condition, clear unknown
// - short idle is declared after two idle symbol pairs
// - second read-only status word at index 0x11 reports filter and connection state
// - second word packs filter, insertion, scrub, connection, signal, flags, break cause
// - first status word at index 0x10, read-only, reports tracker status
// - repeat filter phase codes: 00 repeat, 01 idle, 10 halt one, 11 halt two
// - connection phase codes 0000 off to 1001 maintenance, 1010..1111 reserved
package lcs_pkg;
  // printed offsets are word indexes; byte address is four times the index
  localparam logic [7:0] LCS_IDX_LINK_COND = 8'h10;
  localparam logic [7:0] LCS_IDX_FILT_CONN = 8'h11;
  localparam logic [9:0] LCS_ADDR_LINK_COND = {LCS_IDX_LINK_COND, 2'b00};
  localparam logic [9:0] LCS_ADDR_FILT_CONN = {LCS_IDX_FILT_CONN, 2'b00};
  localparam int LCS_ADDR_W = 10;

  // first status word field positions
  localparam int LCS_REV_LSB = 11;
  localparam int LCS_LOSS_BIT = 10;
  localparam int LCS_PRIOR_LSB = 8;
  localparam int LCS_CUR_LSB = 5;
  localparam int LCS_STATE_BIT = 4;
  localparam int LCS_UNKNOWN_BIT = 3;

  // current condition codes; symbol pair classes share them, idle pairs use 011
  localparam logic [2:0] LCS_COND_NOISE = 3'h0;
  localparam logic [2:0] LCS_COND_ACTIVE = 3'h1;
  localparam logic [2:0] LCS_COND_UNDEF = 3'h2;
  localparam logic [2:0] LCS_COND_SHORT_IDLE = 3'h3;
  localparam logic [2:0] LCS_COND_QUIET = 3'h4;
  localparam logic [2:0] LCS_COND_MASTER = 3'h5;
  localparam logic [2:0] LCS_COND_HALT = 3'h6;
  localparam logic [2:0] LCS_COND_LONG_IDLE = 3'h7;
  localparam logic [2:0] LCS_CLS_IDLE = 3'h3;

  localparam logic [2:0] LCS_PAIRS_FULL = 3'h7;
  localparam logic [2:0] LCS_PAIRS_IDLE = 3'h1;

  // reset values
  localparam logic [2:0] LCS_RST_COND = LCS_COND_NOISE;
  localparam logic [1:0] LCS_RST_PRIOR = 2'h0;
  localparam logic [2:0] LCS_RST_CNT = 3'h0;

  localparam logic [1:0] LCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] LCS_RESP_DECERR = 2'h3;

  typedef enum logic {LCS_SEARCH, LCS_HOLD} lcs_track_e;
endpackage

// file: rtl/lcs_status_regs.sv
// link condition tracker and its two read-only status words on axi4-lite
// assumes classified symbol pairs and filter/connection state come from logic on clk_sys
`timescale 1ns/100ps
module lcs_status_regs #(
  parameter logic [4:0] REVISION_CODE = 5'h15 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lcs_pkg::LCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [lcs_pkg::LCS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // received energy pin
  input wire logic rx_energy_input,
  // classified symbol pairs
  input wire logic pair_valid,
  input wire logic [2:0] pair_class,
  // filter and connection state
  input wire logic [1:0] repeat_filter_phase,
  input wire logic [1:0] insertion_phase,
  input wire logic scrub_flag,
  input wire logic [3:0] connection_phase,
  input wire logic signalling_bit,
  input wire logic link_flag_a,
  input wire logic link_flag_b,
  input wire logic link_flag_c,
  input wire logic [2:0] break_cause_code
);
  import lcs_pkg::*;

  // received energy synchroniser
  logic sync1_q, sync2_q, sync3_q, energy_q, energy_d, loss_q, loss_d;

  always_comb begin
    energy_d = (sync2_q == sync3_q) ? sync3_q : energy_q;
    loss_d = ~energy_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      energy_q <= 1'b0;
      loss_q <= 1'b1;
    end else begin
      sync1_q <= rx_energy_input;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      energy_q <= energy_d;
      loss_q <= loss_d;
    end
  end

  // link condition tracker
  lcs_track_e state_q, state_d;
  logic [2:0] cur_q, cur_d, last_q, last_d, cnt_q, cnt_d;
  logic [1:0] prior_q, prior_d;
  logic unknown_q, unknown_d;

  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    last_d = last_q;
    cnt_d = cnt_q;
    unknown_d = unknown_q;
    if (pair_valid) begin
      if (pair_class != last_q) begin
        // a different pair restarts recognition
        last_d = pair_class;
        cnt_d = LCS_RST_CNT;
        unknown_d = 1'b1;
        state_d = LCS_SEARCH;
      end else if (cnt_q != LCS_PAIRS_FULL) begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_d == LCS_PAIRS_FULL) begin
          // eight like pairs, sixteen symbols
          cur_d = (pair_class == LCS_CLS_IDLE) ? LCS_COND_LONG_IDLE : pair_class;
          unknown_d = 1'b0;
          state_d = LCS_HOLD;
        end else if (pair_class == LCS_CLS_IDLE && cnt_d == LCS_PAIRS_IDLE) begin
          // two idle pairs, four symbols
          cur_d = LCS_COND_SHORT_IDLE;
          unknown_d = 1'b0;
        end
      end
    end
    prior_d = prior_q;
    // only the four upper codes are remembered; their low bits are the prior code
    if (cur_d != cur_q && cur_q[2]) begin
      prior_d = cur_q[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LCS_SEARCH;
      cur_q <= LCS_RST_COND;
      last_q <= LCS_RST_COND;
      cnt_q <= LCS_RST_CNT;
      prior_q <= LCS_RST_PRIOR;
      unknown_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      prior_q <= prior_d;
      unknown_q <= unknown_d;
    end
  end

  // status words
  logic [15:0] word_a, word_b;
  always_comb begin
    word_a = {REVISION_CODE, loss_q, prior_q, cur_q, state_q == LCS_HOLD, unknown_q,
              cnt_q};
    word_b = {repeat_filter_phase, insertion_phase, scrub_flag, connection_phase,
              signalling_bit, link_flag_a, link_flag_b, link_flag_c,
              break_cause_code};
  end

  // axi4-lite slave; writes are accepted and ignored, both words are read-only
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [LCS_ADDR_W-1:0] waddr_q, waddr_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;

  function automatic logic lcs_mapped(input logic [LCS_ADDR_W-1:0] a);
    lcs_mapped = (a == LCS_ADDR_LINK_COND) || (a == LCS_ADDR_FILT_CONN);
  endfunction

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    waddr_d = waddr_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      bvalid_d = 1'b1;
      bresp_d = lcs_mapped(waddr_q) ? LCS_RESP_OKAY : LCS_RESP_DECERR;
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
    end
    awready_d = ~aw_full_d;
    wready_d = ~w_full_d;
  end

  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      // a read only samples the words, no state changes
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = LCS_RESP_OKAY;
      unique case (s_axi_araddr)
        LCS_ADDR_LINK_COND: rdata_d = {16'h0000, word_a};
        LCS_ADDR_FILT_CONN: rdata_d = {16'h0000, word_b};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = LCS_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= LCS_RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= LCS_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      waddr_q <= waddr_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks
  logic [15:0] word_a_seen;
  assign word_a_seen = rdata_q[15:0];

  property p_loss_inverse;
    @(posedge clk_sys) disable iff (!rst_n)
    (sync2_q == sync3_q) |-> ##2 loss_q == ~$past(sync3_q, 2);
  endproperty
  a_loss_inverse: assert property (p_loss_inverse) else $error("loss bit not inverse");

  property p_rev_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_axi_arvalid && arready_q && s_axi_araddr == LCS_ADDR_LINK_COND)
      |=> rvalid_q && word_a_seen[15:11] == REVISION_CODE && word_a_seen[4] == $past(state_q == LCS_HOLD);
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("first word read wrong");

  property p_prior_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (cur_d == cur_q || !cur_q[2]) |=> $stable(prior_q);
  endproperty
  a_prior_hold: assert property (p_prior_hold) else $error("prior changed wrongly");

  property p_prior_load;
    @(posedge clk_sys) disable iff (!rst_n)
    (cur_d != cur_q && cur_q[2]) |=> prior_q == $past(cur_q[1:0]);
  endproperty
  a_prior_load: assert property (p_prior_load) else $error("prior not loaded");

  property p_full_count;
    @(posedge clk_sys) disable iff (!rst_n)
    (pair_valid && pair_class == last_q && cnt_q == 3'h6 && pair_class != LCS_CLS_IDLE)
      |=> cur_q == $past(pair_class) && !unknown_q && cnt_q == LCS_PAIRS_FULL;
  endproperty
  a_full_count: assert property (p_full_count) else $error("eight pairs not recognised");

  property p_short_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    (pair_valid && pair_class == LCS_CLS_IDLE && last_q == LCS_CLS_IDLE && cnt_q == 3'h0)
      |=> cur_q == LCS_COND_SHORT_IDLE && !unknown_q;
  endproperty
  a_short_idle: assert property (p_short_idle) else $error("short idle missed");

  property p_unknown_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (pair_valid && pair_class != last_q) |=> unknown_q && cnt_q == 3'h0 ##1 1'b1;
  endproperty
  a_unknown_set: assert property (p_unknown_set) else $error("unknown flag not set");

  property p_enter_count;
    @(posedge clk_sys) disable iff (!rst_n)
    (cur_q != $past(cur_q))
      |-> cnt_q == LCS_PAIRS_FULL || (cnt_q == LCS_PAIRS_IDLE && cur_q == LCS_COND_SHORT_IDLE);
  endproperty
  a_enter_count: assert property (p_enter_count) else $error("condition entered early");

  property p_word_b;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_axi_arvalid && arready_q && s_axi_araddr == LCS_ADDR_FILT_CONN)
      |=> rdata_q == {16'h0000, $past(word_b)} && rresp_q == LCS_RESP_OKAY;
  endproperty
  a_word_b: assert property (p_word_b) else $error("second word read wrong");

  property p_read_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
    (s_axi_arvalid && arready_q && !pair_valid) |=> $stable(cur_q) && $stable(cnt_q) && $stable(unknown_q);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed tracker");
endmodule // lcs_status_regs

// file: verification/lcs_status_regs_tb.sv
// self-checking bench for the link condition status words over axi4-lite
// assumes lcs_pkg and lcs_status_regs are compiled first; the bench drives every port
`timescale 1ns/100ps
module testbench;
  import lcs_pkg::*;
  localparam logic [4:0] REV = 5'h0A; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [9:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws, conn, v;
  logic [1:0] bresp, rresp, r, rf, ins;
  logic energy, pv, scrub, sig, fa, fb, fc;
  logic [2:0] pc, brk;
  int err_total, checked;
  logic [2:0] seq_c [5] = '{3'h1, 3'h4, 3'h5, 3'h0, 3'h2};
  logic [1:0] seq_p [5] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1};

  always #2 clk_sys = ~clk_sys;

  lcs_status_regs #(.REVISION_CODE(REV)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .rx_energy_input(energy), .pair_valid(pv), .pair_class(pc),
    .repeat_filter_phase(rf), .insertion_phase(ins), .scrub_flag(scrub),
    .connection_phase(conn), .signalling_bit(sig), .link_flag_a(fa),
    .link_flag_b(fb), .link_flag_c(fc), .break_cause_code(brk)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // ready and valid are registered, so the level seen at the falling edge is what the
  // next rising edge samples; this avoids racing the slave's own updates
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er,
                        input string m);
    @(posedge clk_sys);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(negedge clk_sys); while (arr !== 1'b1);
    @(posedge clk_sys);
    arv <= 1'b0;
    do @(negedge clk_sys); while (rv !== 1'b1);
    @(posedge clk_sys);
    chk(rdat, e, m);
    chk({30'h0, rresp}, {30'h0, er}, m);
    rr <= 1'b0;
  endtask

  task automatic wr_word(input logic [9:0] a, output logic [1:0] rsp);
    logic ta, tw, an, wn;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_sys);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= 32'hFFFF_FFFF;
    ws <= 4'hF;
    br <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_sys);
      an = awv & awr;
      wn = wv & wr;
      @(posedge clk_sys);
      if (an) begin
        awv <= 1'b0;
        ta = 1'b1;
      end
      if (wn) begin
        wv <= 1'b0;
        tw = 1'b1;
      end
    end
    do @(negedge clk_sys); while (bv !== 1'b1);
    @(posedge clk_sys);
    rsp = bresp;
    br <= 1'b0;
  endtask

  task automatic pairs(input logic [2:0] c, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pv <= 1'b1;
      pc <= c;
    end
    @(posedge clk_sys);
    pv <= 1'b0;
  endtask

  function automatic logic [31:0] exp_a(logic loss, logic [1:0] pri, logic [2:0] cur,
                                        logic st, logic unk, logic [2:0] cnt);
    return {16'h0, REV, loss, pri, cur, st, unk, cnt};
  endfunction

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    results;
  end

  initial begin
    {awv, wv, br, arv, rr, pv, energy, scrub, sig, fa, fb, fc} = '0;
    {awa, ara, wd, ws, pc, rf, ins, conn, brk} = '0;
    err_total = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(LCS_ADDR_LINK_COND, exp_a(1, 0, 0, 0, 1, 0), LCS_RESP_OKAY, "reset a");
    energy <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 0, 0, 0, 1, 0), LCS_RESP_OKAY, "energy");
    $display("test reset_energy done");
    pairs(LCS_CLS_IDLE, 2);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 0, 3'h3, 0, 0, 1), LCS_RESP_OKAY, "idle2");
    pairs(LCS_CLS_IDLE, 6);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 0, 3'h7, 1, 0, 7), LCS_RESP_OKAY, "idle8");
    pairs(3'h6, 1);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 0, 3'h7, 0, 1, 0), LCS_RESP_OKAY, "search");
    pairs(3'h6, 7);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 3, 3'h6, 1, 0, 7), LCS_RESP_OKAY, "halt");
    for (int i = 0; i < 5; i++) begin
      pairs(seq_c[i], 8);
      rd_chk(LCS_ADDR_LINK_COND, exp_a(0, seq_p[i], seq_c[i], 1, 0, 7), LCS_RESP_OKAY, "step");
    end
    pairs(3'h2, 4);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 1, 3'h2, 1, 0, 7), LCS_RESP_OKAY, "saturate");
    $display("test tracker done");
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      @(posedge clk_sys);
      {rf, ins, scrub, conn, sig} <= {v[1:0], v[3:2], v[0], v, v[1]};
      {fa, fb, fc, brk} <= {v[2], ~v[0], v[3], v[2:0] ^ 3'h5};
      rd_chk(LCS_ADDR_FILT_CONN, {16'h0, v[1:0], v[3:2], v[0], v, v[1], v[2], ~v[0], v[3],
             v[2:0] ^ 3'h5}, LCS_RESP_OKAY, "word b");
    end
    $display("test word_b done");
    wr_word(LCS_ADDR_LINK_COND, r);
    chk({30'h0, r}, {30'h0, LCS_RESP_OKAY}, "write resp");
    rd_chk(LCS_ADDR_LINK_COND, exp_a(0, 1, 3'h2, 1, 0, 7), LCS_RESP_OKAY, "after wr");
    rd_chk(10'h048, 32'h0, LCS_RESP_DECERR, "unmapped rd");
    wr_word(10'h3FC, r);
    chk({30'h0, r}, {30'h0, LCS_RESP_DECERR}, "unmapped wr");
    energy <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd_chk(LCS_ADDR_LINK_COND, exp_a(1, 1, 3'h2, 1, 0, 7), LCS_RESP_OKAY, "loss");
    $display("test access done");
    results;
  end
endmodule // testbench
